//--- rtl/ccpt_phase_cnt.sv
`timescale 1ns/1ns
module ccpt_phase_cnt
   import ccpt_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  load,
   input  wire logic [7:0]            timing,
   output logic                       last
);
   logic [CCPT_CNT_W-1:0] cnt_q;
   logic [CCPT_CNT_W-1:0] cnt_d;
   logic [13:0]           weight;

   always_comb
   begin
      case (timing[CCPT_PRES_MSB:CCPT_PRES_LSB])
         2'b00:   weight = CCPT_WEIGHT_0;
         2'b01:   weight = CCPT_WEIGHT_1;
         2'b10:   weight = CCPT_WEIGHT_2;
         default: weight = CCPT_WEIGHT_3;
      endcase
   end

   // count runs from weight*mult down to zero: mult*weight+1 cycles
   always_comb
   begin
      cnt_d = cnt_q;
      if (load)
         // both operands widened first: 8192 * 63 needs 19 bits
         cnt_d = CCPT_CNT_W'(weight) * CCPT_CNT_W'(timing[CCPT_MULT_MSB:0]);
      else if (cnt_q != '0)
         cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   assign last = (cnt_q == '0);
endmodule

//--- rtl/ccpt_pkg.sv
package ccpt_pkg;
   // register offsets (printed indexes are word indexes, not byte addresses: byte address = 4 * index)
   localparam logic [7:0] CCPT_IDX_SETUP0    = 8'h3a;
   localparam logic [7:0] CCPT_IDX_ACTIVE0   = 8'h3b;
   localparam logic [7:0] CCPT_IDX_RECOVERY0 = 8'h3c;
   localparam logic [7:0] CCPT_IDX_SETUP1    = 8'h3d;
   localparam logic [7:0] CCPT_IDX_ACTIVE1   = 8'h3e;
   localparam logic [7:0] CCPT_IDX_RECOVERY1 = 8'h3f;
   localparam logic [7:0] CCPT_IDX_CTRL      = 8'h40;
   localparam logic [7:0] CCPT_IDX_STATUS    = 8'h41;

   localparam logic [7:0] CCPT_RST_SETUP     = 8'h01;
   localparam logic [7:0] CCPT_RST_ACTIVE0   = 8'h06;
   localparam logic [7:0] CCPT_RST_ACTIVE1   = 8'h0f;
   localparam logic [7:0] CCPT_RST_RECOVERY  = 8'h03;

   localparam int CCPT_PRES_MSB = 7;
   localparam int CCPT_PRES_LSB = 6;
   localparam int CCPT_MULT_MSB = 5;

   localparam logic [13:0] CCPT_WEIGHT_0 = 14'h0001;
   localparam logic [13:0] CCPT_WEIGHT_1 = 14'h0010;
   localparam logic [13:0] CCPT_WEIGHT_2 = 14'h0100;
   localparam logic [13:0] CCPT_WEIGHT_3 = 14'h2000;

   localparam int CCPT_CNT_W = 20;

   typedef enum logic [1:0]
   {
      CCPT_IDLE     = 2'b00,
      CCPT_SETUP    = 2'b01,
      CCPT_ACTIVE   = 2'b10,
      CCPT_RECOVERY = 2'b11
   } ccpt_phase_e;

   typedef enum logic [1:0]
   {
      CCPT_CMD_OE   = 2'b00,
      CCPT_CMD_WE   = 2'b01,
      CCPT_CMD_IORD = 2'b10,
      CCPT_CMD_IOWR = 2'b11
   } ccpt_cmd_e;

   typedef struct packed
   {
      logic [7:0] setup;
      logic [7:0] active;
      logic [7:0] recovery;
   } ccpt_set_s;

   typedef struct packed
   {
      logic        valid;
      ccpt_cmd_e   cmd;
      logic        io_cycle;
   } ccpt_req_s;
endpackage

//--- rtl/ccpt_timer.sv
`timescale 1ns/1ns
module ccpt_timer
   import ccpt_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire ccpt_req_s   req,
   output logic             req_ready,
   output logic             strobe_oe_n,
   output logic             strobe_we_n,
   output logic             strobe_iord_n,
   output logic             strobe_iowr_n,
   output logic             cycle_done
);
   ccpt_set_s   set0_q, set0_d, set1_q, set1_d, sel_set;
   logic [7:0]  winctl_q, winctl_d;
   ccpt_phase_e phase_q, phase_d;
   ccpt_cmd_e   cmd_q, cmd_d;
   logic        useset1_q, useset1_d;
   logic        rdy_q, rdy_d;
   logic [31:0] rdata_q, rdata_d;
   logic        err_q, err_d;
   logic [3:0]  strb_q, strb_d;
   logic        done_q, done_d;
   logic        busrdy_q, busrdy_d;
   logic        load;
   logic [7:0]  timing;
   logic        last;
   logic        access;
   logic        wcommit;
   logic [7:0]  idx;

   function automatic logic idx_ok(input logic [11:0] a);
      idx_ok = (a[1:0] == 2'b00) && (a[11:10] == 2'b00);
   endfunction

   assign access = psel && penable && !busrdy_q;
   // writes land on the pready edge, while the master still holds the request
   assign wcommit = psel && penable && busrdy_q && pwrite && idx_ok(paddr);
   assign idx    = paddr[9:2];

   // one wait state: pready rises on the second access cycle
   always_comb
   begin
      set0_d   = set0_q;
      set1_d   = set1_q;
      winctl_d = winctl_q;
      rdata_d  = rdata_q;
      err_d    = 1'b0;
      busrdy_d = access;
      if (wcommit)
      begin
         case (idx)   // writes update the register at once; the running phase keeps its loaded count
            CCPT_IDX_SETUP0:    set0_d.setup    = pwdata[7:0];
            CCPT_IDX_ACTIVE0:   set0_d.active   = pwdata[7:0];
            CCPT_IDX_RECOVERY0: set0_d.recovery = pwdata[7:0];
            CCPT_IDX_SETUP1:    set1_d.setup    = pwdata[7:0];
            CCPT_IDX_ACTIVE1:   set1_d.active   = pwdata[7:0];
            CCPT_IDX_RECOVERY1: set1_d.recovery = pwdata[7:0];
            CCPT_IDX_CTRL:      winctl_d        = pwdata[7:0];
            default:            winctl_d        = winctl_q;
         endcase
      end
      // status and unmapped writes refused in the first access cycle, so pslverr is ready
      if (access && pwrite && idx_ok(paddr))
         err_d = (idx < CCPT_IDX_SETUP0) || (idx > CCPT_IDX_CTRL);
      else if (access && idx_ok(paddr))
      begin
         rdata_d = 32'h0000_0000;
         case (idx)
            CCPT_IDX_SETUP0:    rdata_d[7:0] = set0_q.setup;
            CCPT_IDX_ACTIVE0:   rdata_d[7:0] = set0_q.active;
            CCPT_IDX_RECOVERY0: rdata_d[7:0] = set0_q.recovery;
            CCPT_IDX_SETUP1:    rdata_d[7:0] = set1_q.setup;
            CCPT_IDX_ACTIVE1:   rdata_d[7:0] = set1_q.active;
            CCPT_IDX_RECOVERY1: rdata_d[7:0] = set1_q.recovery;
            CCPT_IDX_CTRL:      rdata_d[7:0] = winctl_q;
            CCPT_IDX_STATUS:    rdata_d[3:0] = {useset1_q, 1'b0, phase_q};
            default:            err_d        = 1'b1;
         endcase
      end
      else if (access)
      begin
         err_d   = 1'b1;
         rdata_d = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         set0_q   <= '{CCPT_RST_SETUP, CCPT_RST_ACTIVE0, CCPT_RST_RECOVERY};
         set1_q   <= '{CCPT_RST_SETUP, CCPT_RST_ACTIVE1, CCPT_RST_RECOVERY};
         winctl_q <= 8'h00;
         rdata_q  <= 32'h0000_0000;
         err_q    <= 1'b0;
         busrdy_q <= 1'b0;
      end
      else
      begin
         set0_q   <= set0_d;
         set1_q   <= set1_d;
         winctl_q <= winctl_d;
         rdata_q  <= rdata_d;
         err_q    <= err_d;
         busrdy_q <= busrdy_d;
      end
   end

   assign pready  = busrdy_q;
   assign prdata  = rdata_q;
   assign pslverr = err_q;

   // io cycles take bit 3, memory cycles bit 7 of window control
   assign sel_set = useset1_q ? set1_q : set0_q;

   always_comb
   begin
      timing = sel_set.setup;
      case (phase_d)
         CCPT_ACTIVE:   timing = sel_set.active;
         CCPT_RECOVERY: timing = sel_set.recovery;
         default:       timing = sel_set.setup;
      endcase
      if (phase_q == CCPT_IDLE)
         timing = (req.io_cycle ? winctl_q[3] : winctl_q[7]) ? set1_q.setup : set0_q.setup;
   end

   // weight and multiplier decode sits in the counter
   ccpt_phase_cnt u_cnt
   (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (load),
      .timing  (timing),
      .last    (last)
   );

   always_comb
   begin
      phase_d   = phase_q;
      cmd_d     = cmd_q;
      useset1_d = useset1_q;
      done_d    = 1'b0;
      load      = 1'b0;
      case (phase_q)
         CCPT_IDLE:
         begin
            if (req.valid)
            begin
               phase_d   = CCPT_SETUP;
               cmd_d     = req.cmd;
               useset1_d = req.io_cycle ? winctl_q[3] : winctl_q[7];
               load      = 1'b1;
            end
         end
         CCPT_SETUP:
         begin
            if (last)
            begin
               phase_d = CCPT_ACTIVE;
               load    = 1'b1;
            end
         end
         CCPT_ACTIVE:
         begin
            if (last)
            begin
               phase_d = CCPT_RECOVERY;
               load    = 1'b1;
            end
         end
         CCPT_RECOVERY:
         begin
            if (last)
            begin
               phase_d = CCPT_IDLE;
               done_d  = 1'b1;
            end
         end
         default: phase_d = CCPT_IDLE;
      endcase
      strb_d = 4'b1111;
      if (phase_d == CCPT_ACTIVE)
         strb_d[cmd_d] = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_q   <= CCPT_IDLE;
         cmd_q     <= CCPT_CMD_OE;
         useset1_q <= 1'b0;
         strb_q    <= 4'b1111;
         done_q    <= 1'b0;
         rdy_q     <= 1'b0;
      end
      else
      begin
         phase_q   <= phase_d;
         cmd_q     <= cmd_d;
         useset1_q <= useset1_d;
         strb_q    <= strb_d;
         done_q    <= done_d;
         rdy_q     <= rdy_d;
      end
   end

   // ready only while idle, registered, so still high in the cycle a request is taken
   assign rdy_d         = (phase_d == CCPT_IDLE);
   assign req_ready     = rdy_q;
   assign strobe_oe_n   = strb_q[CCPT_CMD_OE];
   assign strobe_we_n   = strb_q[CCPT_CMD_WE];
   assign strobe_iord_n = strb_q[CCPT_CMD_IORD];
   assign strobe_iowr_n = strb_q[CCPT_CMD_IOWR];
   assign cycle_done    = done_q;

   // helper: cycles a strobe has been low
   logic [7:0] low_cnt_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_cnt_q <= 8'h00;
      else if (&strb_q)
         low_cnt_q <= 8'h00;
      else
         low_cnt_q <= low_cnt_q + 8'h01;
   end

   property p_one_strobe;
      @(posedge pclk) disable iff (!presetn) $countones(~strb_q) <= 1;
   endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("two strobes low");

   property p_setup_before;
      @(posedge pclk) disable iff (!presetn) $fell(&strb_q) |-> $past(phase_q) == CCPT_SETUP;
   endproperty
   a_setup_before: assert property (p_setup_before) else $error("strobe without setup");

   property p_active_len;
      @(posedge pclk) disable iff (!presetn)
         ($rose(&strb_q) && sel_set.active[7:6] == 2'b00) |-> low_cnt_q == sel_set.active[5:0] + 8'h01;
   endproperty
   a_active_len: assert property (p_active_len) else $error("active length wrong");

   property p_setup_zero;
      @(posedge pclk) disable iff (!presetn)
         (phase_q == CCPT_IDLE && req.valid && timing[CCPT_MULT_MSB:0] == 6'h00) |=> ##1 phase_q == CCPT_ACTIVE;
   endproperty
   a_setup_zero: assert property (p_setup_zero) else $error("one cycle setup wrong");

   property p_recov_follow;
      @(posedge pclk) disable iff (!presetn) $rose(&strb_q) |-> phase_q == CCPT_RECOVERY;
   endproperty
   a_recov_follow: assert property (p_recov_follow) else $error("no recovery after strobe");

   property p_order;
      @(posedge pclk) disable iff (!presetn)
         phase_q == CCPT_ACTIVE |=> phase_q inside {CCPT_ACTIVE, CCPT_RECOVERY};
   endproperty
   a_order: assert property (p_order) else $error("phase order broken");

   property p_reset_act;
      @(posedge pclk) $rose(presetn) |-> set0_q.active == 8'h06 && set1_q.active == 8'h0f;
   endproperty
   a_reset_act: assert property (p_reset_act) else $error("active reset value wrong");

   property p_write_now;
      @(posedge pclk) disable iff (!presetn)
         (wcommit && idx == CCPT_IDX_ACTIVE1) |=> set1_q.active == $past(pwdata[7:0]);
   endproperty
   a_write_now: assert property (p_write_now) else $error("write not immediate");

   property p_done;
      @(posedge pclk) disable iff (!presetn) cycle_done |-> phase_q == CCPT_IDLE;
   endproperty
   a_done: assert property (p_done) else $error("done outside idle");

   c_iord: cover property (@(posedge pclk) disable iff (!presetn) !strobe_iord_n);
   c_set1: cover property (@(posedge pclk) disable iff (!presetn) useset1_q && !strobe_oe_n);
   c_done: cover property (@(posedge pclk) disable iff (!presetn) cycle_done);
endmodule

//--- test/ccpt_card_model.sv
`timescale 1ns/1ns
// card side: counts strobe-low cycles and records which strobes were seen
module ccpt_card_model
(
   input  wire logic pclk,
   input  wire logic clr,
   input  wire logic strobe_oe_n,
   input  wire logic strobe_we_n,
   input  wire logic strobe_iord_n,
   input  wire logic strobe_iowr_n,
   output int        low_cnt,
   output logic [3:0] seen
);
   logic [3:0] act;

   assign act = ~{strobe_iowr_n, strobe_iord_n, strobe_we_n, strobe_oe_n};

   always @(posedge pclk)
   begin
      if (clr)
      begin
         low_cnt <= 0;
         seen    <= 4'h0;
      end
      else if (|act)
      begin
         low_cnt <= low_cnt + 1;
         seen    <= seen | act;
      end
   end
endmodule

//--- test/tb.sv
`timescale 1ns/1ns
module tb
   import ccpt_pkg::*;
;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   ccpt_req_s   req;
   logic        req_ready;
   logic        oe_n;
   logic        we_n;
   logic        iord_n;
   logic        iowr_n;
   logic        cycle_done;
   logic        clr;
   int          low_cnt;
   logic [3:0]  seen;
   int          failures;
   int          tests_run;
   logic [31:0] r;
   logic        e;
   logic [7:0]  rv [6];

   ccpt_timer ccpt_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .req(req), .req_ready(req_ready), .strobe_oe_n(oe_n),
      .strobe_we_n(we_n), .strobe_iord_n(iord_n), .strobe_iowr_n(iowr_n), .cycle_done(cycle_done));

   ccpt_card_model ccpt_card_model_i (.pclk(pclk), .clr(clr), .strobe_oe_n(oe_n), .strobe_we_n(we_n),
      .strobe_iord_n(iord_n), .strobe_iowr_n(iowr_n), .low_cnt(low_cnt), .seen(seen));

   always #5 pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         chk(32'h0000_0000, 32'h0000_0001);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, {24'h00_0000, d});
      chk({31'h0, e}, 32'h0000_0000);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      chk({24'h00_0000, r[7:0]}, {24'h00_0000, exp});
   endtask

   // strobe after s+1 edges from the take edge, low a cycles, done r cycles later
   task automatic cyc(input ccpt_cmd_e c, input logic io, input int s, input int a, input int rr);
      int n;
      @(posedge pclk);
      clr <= 1'b1;
      req <= '{1'b1, c, io};
      @(posedge pclk);
      clr       <= 1'b0;
      req.valid <= 1'b0;
      n = 0;
      do
      begin
         @(negedge pclk);
         n++;
      end
      while ((oe_n & we_n & iord_n & iowr_n) && n < 100);
      chk(n, s + 1);
      chk({31'h0, req_ready}, 32'h0000_0000);
      n = 0;
      do
      begin
         @(negedge pclk);
         n++;
      end
      while (!(oe_n & we_n & iord_n & iowr_n) && n < 300);
      chk(low_cnt, a);
      chk({28'h0, seen}, 32'h1 << c);
      n = 0;
      do
      begin
         @(negedge pclk);
         n++;
      end
      while (cycle_done !== 1'b1 && n < 9000);
      chk(n, rr);
      chk({31'h0, req_ready}, 32'h0000_0001);
   endtask

   task automatic results();
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #300_000;
      failures++;
      results();
   end

   initial
   begin
      pclk = 0;
      presetn = 0;
      {psel, penable, pwrite, clr} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      req = '0;
      rv = '{8'h01, 8'h06, 8'h03, 8'h01, 8'h0f, 8'h03};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++)
         rd(CCPT_IDX_SETUP0 + 8'(i), rv[i]);
      apb(1'b0, 8'h50, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
      cyc(CCPT_CMD_OE, 1'b0, 2, 7, 4);
      // set 1: top multiplier, weight 16, zero recovery
      wr(CCPT_IDX_SETUP1, 8'h3f);
      wr(CCPT_IDX_ACTIVE1, 8'h41);
      wr(CCPT_IDX_RECOVERY1, 8'h00);
      wr(CCPT_IDX_CTRL, 8'h08);
      rd(CCPT_IDX_ACTIVE1, 8'h41);
      cyc(CCPT_CMD_IORD, 1'b1, 64, 17, 1);
      rd(CCPT_IDX_STATUS, 8'h08);
      apb(1'b1, CCPT_IDX_STATUS, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
      cyc(CCPT_CMD_WE, 1'b0, 2, 7, 4);
      // set 0: zero setup multiplier at the top weight, weights 256 and 8192
      wr(CCPT_IDX_SETUP0, 8'hc0);
      wr(CCPT_IDX_ACTIVE0, 8'h81);
      wr(CCPT_IDX_RECOVERY0, 8'hc1);
      wr(CCPT_IDX_CTRL, 8'h80);
      cyc(CCPT_CMD_OE, 1'b0, 64, 17, 1);
      cyc(CCPT_CMD_IOWR, 1'b1, 1, 257, 8193);
      // reset in mid-run, block idle: every register comes back
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++)
         rd(CCPT_IDX_SETUP0 + 8'(i), rv[i]);
      rd(CCPT_IDX_CTRL, 8'h00);
      results();
   end
endmodule
